// [glm_load_relax.sv]
`timescale 1ns/1ps
`default_nettype none
`include "glm_cfg.svh"
module glm_load_relax #(
	parameter int unsigned TICK_CYCLES = `GLM_TICK_CYCLES,
	parameter int unsigned OCV_WAIT_S = `GLM_OCV_WAIT_S
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [`GLM_ADDR_W-1:0] reg_addr,
	input wire logic [`GLM_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`GLM_DATA_W-1:0] reg_rdata,
	input wire glm_pkg::glm_meas_type meas,
	input wire logic learn_cycle,
	input wire logic ra_learned,
	input wire logic [15:0] qmax_candidate,
	input wire logic qmax_candidate_valid,
	output logic [15:0] load_rate,
	output logic load_model_flag,
	output logic [15:0] reserve_mah,
	output logic [15:0] reserve_cwh,
	output logic reserve_comp_select,
	output logic dsg_active,
	output logic chg_active,
	output logic relax_active,
	output logic ocv_read_en,
	output logic qmax_update_en,
	output logic [15:0] qmax
);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam int LPF_K = `GLM_LPF_K;

	// Averager divider needs about 36 clocks between samples
	if (TICK_CYCLES < 40 || OCV_WAIT_S < 1 || OCV_WAIT_S > 65535) begin : g_chk
		$error("glm_load_relax: timing parameters out of range");
	end

	function automatic logic [15:0] glm_mag(input logic signed [15:0] v);
		glm_mag = v[15] ? 16'(-v) : 16'(v);
	endfunction : glm_mag

	// Current mA times voltage mV gives uW; scale to 10 mW units
	function automatic logic [15:0] glm_cw(input logic [15:0] i,
		input logic [15:0] v);
		logic [45:0] p;
		p = 46'(i) * 46'(v) * 46'(`GLM_CW_MUL);
		glm_cw = 16'(p >> `GLM_CW_SHIFT);
	endfunction : glm_cw

	logic [15:0] cfg_reg, dsg_thr_reg, chg_thr_reg, quit_reg;
	logic [15:0] dsg_relax_reg, chg_relax_reg, quit_relax_reg;
	logic [15:0] des_cap_reg, des_energy_reg, hypo_rate_reg, user_rate_reg;
	logic [7:0] upd_status_reg;
	logic [TW-1:0] tick_cnt_reg;
	logic tick_reg;
	logic [15:0] below_cnt_reg, above_cnt_reg, relax_cnt_reg;
	glm_pkg::glm_state_type state_reg;
	logic [31:0] filt_reg, filt_next;
	logic [15:0] i_now, i_last, p_now, p_last;
	logic [15:0] rate_next;
	logic [15:0] rdata_next;
	logic [15:0] status_word;

	wire logic wr_hit = reg_wr;
	wire logic mode_power = cfg_reg[`GLM_CFG_MODE_BIT];
	wire logic [2:0] load_sel = cfg_reg[`GLM_CFG_SEL_MSB:`GLM_CFG_SEL_LSB];
	wire logic [15:0] mean_mag = glm_mag(meas.mean_current);
	wire logic [15:0] inst_mag = glm_mag(meas.inst_current);
	wire logic [15:0] inst_pw = glm_cw(inst_mag, meas.voltage);
	wire logic dsg_now = meas.inst_current < 0 && inst_mag > dsg_thr_reg;
	wire logic gauge_en = upd_status_reg[2];
	wire logic subcmd_en = reg_wr && reg_addr == `GLM_REG_SUBCMD
		&& reg_wdata == `GLM_SUBCMD_GAUGE_EN;
	wire logic below_quit = mean_mag < quit_reg;
	wire logic qmax_take = qmax_candidate_valid & qmax_update_en;

	// ==========================================
	// One second tick for all timers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// ==========================================
	// Host configuration
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_reg <= `GLM_CFG_RST;
			reserve_mah <= `GLM_RES_MAH_RST;
			reserve_cwh <= `GLM_RES_CWH_RST;
			dsg_thr_reg <= `GLM_DSG_THR_RST;
			chg_thr_reg <= `GLM_CHG_THR_RST;
			quit_reg <= `GLM_QUIT_CUR_RST;
			dsg_relax_reg <= `GLM_DSG_RELAX_RST;
			chg_relax_reg <= `GLM_CHG_RELAX_RST;
			quit_relax_reg <= `GLM_QUIT_RELAX_RST;
			des_cap_reg <= `GLM_DES_CAP_RST;
			des_energy_reg <= `GLM_DES_ENERGY_RST;
			hypo_rate_reg <= '0;
			user_rate_reg <= '0;
		end else if (wr_hit) begin
			unique case (reg_addr)
			`GLM_REG_CONFIG: cfg_reg <= reg_wdata;
			`GLM_REG_RES_MAH: reserve_mah <= reg_wdata;
			`GLM_REG_RES_CWH: reserve_cwh <= reg_wdata;
			`GLM_REG_DSG_THR: dsg_thr_reg <= reg_wdata;
			`GLM_REG_CHG_THR: chg_thr_reg <= reg_wdata;
			`GLM_REG_QUIT_CUR: quit_reg <= reg_wdata;
			`GLM_REG_DSG_RELAX: dsg_relax_reg <= reg_wdata;
			`GLM_REG_CHG_RELAX: chg_relax_reg <= reg_wdata;
			`GLM_REG_QUIT_RELAX: quit_relax_reg <= reg_wdata;
			`GLM_REG_DES_CAP: des_cap_reg <= reg_wdata;
			`GLM_REG_DES_ENERGY: des_energy_reg <= reg_wdata;
			`GLM_REG_HYPO_RATE: hypo_rate_reg <= reg_wdata;
			`GLM_REG_USER_RATE: user_rate_reg <= reg_wdata;
			default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			load_model_flag <= 1'b0;
			reserve_comp_select <= 1'b0;
		end else begin
			load_model_flag <= mode_power;
			reserve_comp_select <= cfg_reg[`GLM_CFG_RESERVE_COMP_SELECT_BIT];
		end
	end

	// ==========================================
	// Current direction, sampled once a second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dsg_active <= 1'b0;
			chg_active <= 1'b0;
		end else if (tick_reg) begin
			dsg_active <= dsg_now;
			chg_active <= meas.inst_current > 0
				&& inst_mag > chg_thr_reg;
		end
	end

	// ==========================================
	// Relaxation tracking
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			below_cnt_reg <= '0;
			above_cnt_reg <= '0;
		end else if (tick_reg) begin
			// Broken condition restarts the timer
			below_cnt_reg <= below_quit
				? below_cnt_reg + {15'h0000, below_cnt_reg != '1}
				: '0;
			above_cnt_reg <= !below_quit
				? above_cnt_reg + {15'h0000, above_cnt_reg != '1}
				: '0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= glm_pkg::GLM_ACTIVE;
		end else if (tick_reg) begin
			unique case (state_reg)
			glm_pkg::GLM_ACTIVE: begin
				if (below_quit && (below_cnt_reg + 1'b1 >= dsg_relax_reg
					|| below_cnt_reg + 1'b1 >= chg_relax_reg)) begin
					state_reg <= glm_pkg::GLM_RELAX;
				end
			end
			glm_pkg::GLM_RELAX: begin
				if (!below_quit
					&& above_cnt_reg + 1'b1 >= quit_relax_reg) begin
					state_reg <= glm_pkg::GLM_ACTIVE;
				end
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			relax_cnt_reg <= '0;
		end else if (state_reg != glm_pkg::GLM_RELAX) begin
			relax_cnt_reg <= '0;
		end else if (tick_reg && relax_cnt_reg != '1) begin
			relax_cnt_reg <= relax_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			relax_active <= 1'b0;
			ocv_read_en <= 1'b0;
			qmax_update_en <= 1'b0;
		end else begin
			relax_active <= state_reg == glm_pkg::GLM_RELAX;
			ocv_read_en <= state_reg == glm_pkg::GLM_RELAX
				&& relax_cnt_reg >= 16'(OCV_WAIT_S);
			qmax_update_en <= state_reg == glm_pkg::GLM_RELAX
				&& relax_cnt_reg >= 16'(OCV_WAIT_S)
				&& meas.dvdt_uv < `GLM_DVDT_MAX_UV;
		end
	end

	// ==========================================
	// Capacity and learning status
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			qmax <= `GLM_DES_CAP_RST;
		end else if (qmax_take) begin
			// Gauging result wins over a host write
			qmax <= qmax_candidate;
		end else if (wr_hit && reg_addr == `GLM_REG_QMAX) begin
			qmax <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			upd_status_reg <= `GLM_US_LEARNED_OFF;
		end else if (subcmd_en) begin
			upd_status_reg <= upd_status_reg == `GLM_US_LEARNED_OFF
				? `GLM_US_LEARNED : `GLM_US_UNLEARNED;
		end else if (learn_cycle && gauge_en) begin
			if (qmax_take && upd_status_reg == `GLM_US_UNLEARNED) begin
				upd_status_reg <= `GLM_US_QMAX_ONLY;
			end else if (ra_learned
				&& upd_status_reg == `GLM_US_QMAX_ONLY) begin
				upd_status_reg <= `GLM_US_LEARNED;
			end
		end
	end

	// ==========================================
	// Load sources
	// Samples only real discharge, not the tick that ends the cycle
	glm_cycle_avg #(.W(16), .CW(16)) u_avg_i (
		.clk(clk),
		.rst_b(rst_b),
		.sample_tick(tick_reg & dsg_now),
		.in_cycle(dsg_active),
		.sample(inst_mag),
		.present_avg(i_now),
		.last_avg(i_last)
	);

	glm_cycle_avg #(.W(16), .CW(16)) u_avg_p (
		.clk(clk),
		.rst_b(rst_b),
		.sample_tick(tick_reg & dsg_now),
		.in_cycle(dsg_active),
		.sample(inst_pw),
		.present_avg(p_now),
		.last_avg(p_last)
	);

	// First-order filter in 16.16 fixed point, stepped once a second
	always_comb begin
		logic signed [33:0] diff;
		logic signed [49:0] prod;
		diff = $signed({2'b00, mean_mag, 16'h0000})
			- $signed({2'b00, filt_reg});
		prod = 50'(diff) * 50'(LPF_K);
		filt_next = 32'($signed(34'(filt_reg)) + 34'(prod >>> 16));
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			filt_reg <= '0;
		end else if (tick_reg) begin
			filt_reg <= filt_next;
		end
	end

	always_comb begin
		unique case (load_sel)
		3'h0: rate_next = mode_power ? p_last : i_last;
		3'h1: rate_next = mode_power ? p_now : i_now;
		3'h2: rate_next = mode_power
			? glm_cw(mean_mag, meas.voltage) : mean_mag;
		3'h3: rate_next = mode_power
			? glm_cw(filt_reg[31:16], meas.voltage)
			: filt_reg[31:16];
		3'h4: rate_next = (mode_power ? des_energy_reg : des_cap_reg)
			/ `GLM_C_RATE_DIV;
		3'h5: rate_next = hypo_rate_reg;
		3'h6: rate_next = user_rate_reg;
		default: rate_next = mode_power ? p_last : i_now;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			load_rate <= '0;
		end else begin
			load_rate <= rate_next;
		end
	end

	// ==========================================
	// Read port, data valid only in the cycle after the strobe
	always_comb begin
		status_word = '0;
		status_word[`GLM_ST_MODE_BIT] = load_model_flag;
		status_word[`GLM_ST_RELAX_BIT] = relax_active;
		status_word[`GLM_ST_DSG_BIT] = dsg_active;
		status_word[`GLM_ST_CHG_BIT] = chg_active;
		status_word[`GLM_ST_OCV_BIT] = ocv_read_en;
		status_word[`GLM_ST_QUPD_BIT] = qmax_update_en;
		status_word[`GLM_ST_EN_BIT] = gauge_en;
		unique case (reg_addr)
		`GLM_REG_STATUS: rdata_next = status_word;
		`GLM_REG_CONFIG: rdata_next = cfg_reg;
		`GLM_REG_RES_MAH: rdata_next = reserve_mah;
		`GLM_REG_RES_CWH: rdata_next = reserve_cwh;
		`GLM_REG_DSG_THR: rdata_next = dsg_thr_reg;
		`GLM_REG_CHG_THR: rdata_next = chg_thr_reg;
		`GLM_REG_QUIT_CUR: rdata_next = quit_reg;
		`GLM_REG_DSG_RELAX: rdata_next = dsg_relax_reg;
		`GLM_REG_CHG_RELAX: rdata_next = chg_relax_reg;
		`GLM_REG_QUIT_RELAX: rdata_next = quit_relax_reg;
		`GLM_REG_DES_CAP: rdata_next = des_cap_reg;
		`GLM_REG_DES_ENERGY: rdata_next = des_energy_reg;
		`GLM_REG_HYPO_RATE: rdata_next = hypo_rate_reg;
		`GLM_REG_USER_RATE: rdata_next = user_rate_reg;
		`GLM_REG_QMAX: rdata_next = qmax;
		`GLM_REG_UPD_STATUS: rdata_next = {8'h00, upd_status_reg};
		`GLM_REG_AVG_I_LAST: rdata_next = i_last;
		`GLM_REG_AVG_P_LAST: rdata_next = p_last;
		`GLM_REG_LOAD_RATE: rdata_next = load_rate;
		default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : '0;
		end
	end
endmodule : glm_load_relax
`default_nettype wire

// [glm_cfg.svh]
`ifndef GLM_CFG_SVH
`define GLM_CFG_SVH
// ==========================================
// Register bus geometry
`define GLM_ADDR_W 5
`define GLM_DATA_W 16
// ==========================================
// Register indices
`define GLM_REG_STATUS 5'h00
`define GLM_REG_CONFIG 5'h01
`define GLM_REG_RES_MAH 5'h02
`define GLM_REG_RES_CWH 5'h03
`define GLM_REG_DSG_THR 5'h04
`define GLM_REG_CHG_THR 5'h05
`define GLM_REG_QUIT_CUR 5'h06
`define GLM_REG_DSG_RELAX 5'h07
`define GLM_REG_CHG_RELAX 5'h08
`define GLM_REG_QUIT_RELAX 5'h09
`define GLM_REG_DES_CAP 5'h0a
`define GLM_REG_DES_ENERGY 5'h0b
`define GLM_REG_HYPO_RATE 5'h0c
`define GLM_REG_USER_RATE 5'h0d
`define GLM_REG_QMAX 5'h0e
`define GLM_REG_UPD_STATUS 5'h0f
`define GLM_REG_SUBCMD 5'h10
`define GLM_REG_AVG_I_LAST 5'h11
`define GLM_REG_AVG_P_LAST 5'h12
`define GLM_REG_LOAD_RATE 5'h13
// ==========================================
// Field positions
`define GLM_CFG_MODE_BIT 0
`define GLM_CFG_SEL_LSB 1
`define GLM_CFG_SEL_MSB 3
`define GLM_CFG_RESERVE_COMP_SELECT_BIT 4
`define GLM_ST_MODE_BIT 0
`define GLM_ST_RELAX_BIT 1
`define GLM_ST_DSG_BIT 2
`define GLM_ST_CHG_BIT 3
`define GLM_ST_OCV_BIT 4
`define GLM_ST_QUPD_BIT 5
`define GLM_ST_EN_BIT 6
// ==========================================
// Reset values
`define GLM_CFG_RST 16'h0002
`define GLM_RES_MAH_RST 16'h0000
`define GLM_RES_CWH_RST 16'h0000
`define GLM_DSG_THR_RST 16'h003c
`define GLM_CHG_THR_RST 16'h0064
`define GLM_QUIT_CUR_RST 16'h000a
`define GLM_DSG_RELAX_RST 16'h0384
`define GLM_CHG_RELAX_RST 16'h003c
`define GLM_QUIT_RELAX_RST 16'h003c
`define GLM_DES_CAP_RST 16'h03e8
`define GLM_DES_ENERGY_RST 16'h0172
`define GLM_US_LEARNED_OFF 8'h02
`define GLM_US_UNLEARNED 8'h04
`define GLM_US_QMAX_ONLY 8'h05
`define GLM_US_LEARNED 8'h06
`define GLM_SUBCMD_GAUGE_EN 16'h0021
// ==========================================
// Timing and arithmetic
`define GLM_CLK_HZ 20000000
`define GLM_TICK_MS 1000
`define GLM_TICK_CYCLES (`GLM_CLK_HZ / 1000 * `GLM_TICK_MS)
`define GLM_OCV_WAIT_MIN 6
`define GLM_OCV_WAIT_S (`GLM_OCV_WAIT_MIN * 60)
`define GLM_DVDT_MAX_UV 16'h0004
`define GLM_LPF_TAU_S 14
`define GLM_LPF_K (65536 / `GLM_LPF_TAU_S)
`define GLM_C_RATE_DIV 16'h0005
`define GLM_CW_MUL 6711
`define GLM_CW_SHIFT 26
`endif

// [glm_pkg.sv]
package glm_pkg;
	typedef enum logic {GLM_ACTIVE, GLM_RELAX} glm_state_type;
	// Negative current is discharge
	typedef struct packed {
		logic signed [15:0] inst_current;
		logic signed [15:0] mean_current;
		logic [15:0] voltage;
		logic [15:0] dvdt_uv;
	} glm_meas_type;
endpackage : glm_pkg

// [glm_cycle_avg.sv]
`timescale 1ns/1ps
`default_nettype none
module glm_cycle_avg #(
	parameter int W = 16,
	parameter int CW = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sample_tick,
	input wire logic in_cycle,
	input wire logic [W-1:0] sample,
	output logic [W-1:0] present_avg,
	output logic [W-1:0] last_avg
);
	localparam int SW = W + CW;
	localparam int STW = $clog2(SW + 1);
	logic [SW-1:0] sum_reg, dvd_reg, quo_reg;
	logic [CW-1:0] cnt_reg;
	logic [CW:0] rem_reg, rem_sh;
	logic [STW-1:0] step_reg;
	logic cyc_d_reg, go_reg;
	wire logic rise = in_cycle & ~cyc_d_reg;
	wire logic fall = ~in_cycle & cyc_d_reg;
	// Count saturates so a very long cycle keeps its average
	wire logic take = sample_tick & in_cycle & (rise | (cnt_reg != '1));

	if (W < 2 || CW < 2) begin : g_chk
		$error("glm_cycle_avg: widths too small");
	end

	// ==========================================
	// Accumulation
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sum_reg <= '0;
			cnt_reg <= '0;
			cyc_d_reg <= 1'b0;
			go_reg <= 1'b0;
		end else begin
			cyc_d_reg <= in_cycle;
			go_reg <= take;
			if (take) begin
				sum_reg <= (rise ? '0 : sum_reg) + SW'(sample);
				cnt_reg <= (rise ? '0 : cnt_reg) + 1'b1;
			end else if (rise) begin
				sum_reg <= '0;
				cnt_reg <= '0;
			end
		end
	end

	// ==========================================
	// Serial divider, one quotient bit a clock
	assign rem_sh = {rem_reg[CW-1:0], dvd_reg[SW-1]};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dvd_reg <= '0;
			quo_reg <= '0;
			rem_reg <= '0;
			step_reg <= '0;
			present_avg <= '0;
		end else if (go_reg) begin
			dvd_reg <= sum_reg;
			quo_reg <= '0;
			rem_reg <= '0;
			step_reg <= STW'(SW);
		end else if (step_reg != '0) begin
			dvd_reg <= {dvd_reg[SW-2:0], 1'b0};
			step_reg <= step_reg - 1'b1;
			if (rem_sh >= {1'b0, cnt_reg}) begin
				rem_reg <= rem_sh - {1'b0, cnt_reg};
				quo_reg <= {quo_reg[SW-2:0], 1'b1};
			end else begin
				rem_reg <= rem_sh;
				quo_reg <= {quo_reg[SW-2:0], 1'b0};
			end
		end else if (cnt_reg != '0) begin
			present_avg <= quo_reg[W-1:0];
		end
	end

	// ==========================================
	// Cycle end keeps the average
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last_avg <= '0;
		end else if (fall) begin
			last_avg <= present_avg;
		end
	end
endmodule : glm_cycle_avg
`default_nettype wire

// [glm_load_relax_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "glm_cfg.svh"
module glm_load_relax_checker #(
	parameter int unsigned TICK_CYCLES = 20,
	parameter int unsigned OCV_WAIT_S = 3
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire glm_pkg::glm_meas_type meas,
	input wire logic [15:0] load_rate,
	input wire logic load_model_flag,
	input wire logic [15:0] reserve_mah,
	input wire logic reserve_comp_select,
	input wire logic relax_active,
	input wire logic ocv_read_en,
	input wire logic qmax_update_en
);
	// ====
	// Shadows and run counters
	logic [3:0] cfg_sh;
	logic [15:0] hyp_sh;
	logic [2:0] age;
	logic [31:0] lo_cnt, hi_cnt, rx_cnt;
	logic signed [15:0] mc;
	logic below;
	assign mc = meas.mean_current;
	assign below = mc > -16'sh000a && mc < 16'sh000a;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_sh <= 4'h2;
			hyp_sh <= 16'h0000;
			age <= 3'h0;
		end else if (reg_wr && reg_addr == `GLM_REG_CONFIG) begin
			cfg_sh <= reg_wdata[3:0];
			age <= 3'h0;
		end else if (reg_wr && reg_addr == `GLM_REG_HYPO_RATE) begin
			hyp_sh <= reg_wdata;
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	// Saturation keeps long quiet runs from wrapping
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lo_cnt <= '0;
			hi_cnt <= '0;
			rx_cnt <= '0;
		end else begin
			lo_cnt <= below ? lo_cnt + 32'(lo_cnt != '1) : '0;
			hi_cnt <= (!below && mc != 16'sh000a && mc != -16'sh000a) ?
				hi_cnt + 32'(hi_cnt != '1) : '0;
			rx_cnt <= relax_active ? rx_cnt + 32'(rx_cnt != '1) : '0;
		end
	end
	// ====
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_cfg_wr;
		reg_wr && reg_addr == `GLM_REG_CONFIG;
	endsequence
	sequence s_settled(logic [2:0] s);
		age == 3'h7 && cfg_sh[3:1] == s;
	endsequence
	property p_mode;
		s_cfg_wr |-> ##2 load_model_flag == $past(reg_wdata[0], 2);
	endproperty
	property p_comp;
		s_cfg_wr |-> ##2 reserve_comp_select == $past(reg_wdata[4], 2);
	endproperty
	property p_stat;
		reg_rd && reg_addr == `GLM_REG_STATUS |=>
			reg_rdata[0] == $past(load_model_flag);
	endproperty
	property p_resv;
		reg_wr && reg_addr == `GLM_REG_RES_MAH |->
			##2 reserve_mah == $past(reg_wdata, 2);
	endproperty
	property p_c5;
		s_settled(3'h4) |->
			load_rate == (cfg_sh[0] ? 16'h004a : 16'h00c8);
	endproperty
	property p_hyp;
		s_settled(3'h5) |-> load_rate == hyp_sh;
	endproperty
	property p_in;
		$rose(relax_active) |-> lo_cnt >= 59 * TICK_CYCLES;
	endproperty
	property p_out;
		$fell(relax_active) |-> hi_cnt >= 59 * TICK_CYCLES;
	endproperty
	property p_ocv;
		$rose(ocv_read_en) |->
			relax_active && rx_cnt >= (OCV_WAIT_S - 1) * TICK_CYCLES;
	endproperty
	property p_qupd;
		$rose(qmax_update_en) |->
			relax_active && $past(meas.dvdt_uv) < 16'h0004;
	endproperty
	a_mode: assert property (p_mode) else $error("mode flag wrong");
	a_comp: assert property (p_comp) else $error("comp bit wrong");
	a_stat: assert property (p_stat) else $error("status mode wrong");
	a_resv: assert property (p_resv) else $error("reserve wrong");
	a_c5: assert property (p_c5) else $error("C/5 rate wrong");
	a_hyp: assert property (p_hyp) else $error("hypo rate wrong");
	a_in: assert property (p_in) else $error("early relax entry");
	a_out: assert property (p_out) else $error("early relax exit");
	a_ocv: assert property (p_ocv) else $error("early ocv");
	a_qupd: assert property (p_qupd) else $error("bad qmax gate");
endmodule : glm_load_relax_checker
bind glm_load_relax glm_load_relax_checker #(
	.TICK_CYCLES(TICK_CYCLES),
	.OCV_WAIT_S(OCV_WAIT_S)
) u_glm_load_relax_checker (
	.clk(clk),
	.rst_b(rst_b),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.meas(meas),
	.load_rate(load_rate),
	.load_model_flag(load_model_flag),
	.reserve_mah(reserve_mah),
	.reserve_comp_select(reserve_comp_select),
	.relax_active(relax_active),
	.ocv_read_en(ocv_read_en),
	.qmax_update_en(qmax_update_en)
);
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int unsigned TK = 40;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic learn_cycle = 1'b0;
	logic ra_learned = 1'b0;
	logic [15:0] qmax_candidate = 16'h0000;
	logic qmax_candidate_valid = 1'b0;
	glm_pkg::glm_meas_type meas = '0;
	logic [15:0] reg_rdata, load_rate, reserve_mah, reserve_cwh, qmax;
	logic load_model_flag, reserve_comp_select, dsg_active, chg_active;
	logic relax_active, ocv_read_en, qmax_update_en;
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [15:0] rst_tbl [0:19] = '{16'h0000, 16'h0002, 16'h0000,
		16'h0000, 16'h003c, 16'h0064, 16'h000a, 16'h0384, 16'h003c,
		16'h003c, 16'h03e8, 16'h0172, 16'h0000, 16'h0000, 16'h03e8,
		16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	// Select 0 in power mode returns last average power
	logic [15:0] lcfg [0:10] = '{16'h0008, 16'h000a, 16'h000c, 16'h0009,
		16'h000b, 16'h000d, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
		16'h0005};
	logic [15:0] lexp [0:10] = '{16'h00c8, 16'h0123, 16'h0456, 16'h004a,
		16'h0123, 16'h0456, 16'h0026, 16'h0064, 16'h0026, 16'h0032,
		16'h0013};
	glm_load_relax #(.TICK_CYCLES(TK), .OCV_WAIT_S(3)) u_glm_load_relax (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas(meas), .learn_cycle(learn_cycle),
		.ra_learned(ra_learned), .qmax_candidate(qmax_candidate),
		.qmax_candidate_valid(qmax_candidate_valid),
		.load_rate(load_rate), .load_model_flag(load_model_flag),
		.reserve_mah(reserve_mah), .reserve_cwh(reserve_cwh),
		.reserve_comp_select(reserve_comp_select),
		.dsg_active(dsg_active), .chg_active(chg_active),
		.relax_active(relax_active), .ocv_read_en(ocv_read_en),
		.qmax_update_en(qmax_update_en), .qmax(qmax));
	always #25 clk = ~clk;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Lowering then idling one edge avoids double assignment
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
		@(posedge clk);
	endtask : rd
	task automatic ticks(input int n);
		repeat (n * TK) @(posedge clk);
	endtask : ticks
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 19; i++)
			if (i != 16) rd(5'(i), rst_tbl[i]);
		rd(5'h1f, 16'h0000);
		wr(5'h0f, 16'h0006);
		wr(5'h00, 16'h00ff);
		rd(5'h0f, 16'h0002);
		$display("test reset done");
		meas.voltage <= 16'h0ed8;
		meas.mean_current <= 16'h0032;
		meas.inst_current <= 16'hff9c;
		ticks(3);
		chk(dsg_active, 1'b1);
		meas.inst_current <= 16'h00c8;
		ticks(2);
		chk({dsg_active, chg_active}, 2'b01);
		meas.inst_current <= 16'h0000;
		ticks(2);
		chk({dsg_active, chg_active}, 2'b00);
		rd(5'h11, 16'h0064);
		rd(5'h12, 16'h0026);
		wr(5'h01, 16'h0000);
		repeat (4) @(posedge clk);
		chk(load_rate, 16'h0064);
		$display("test average done");
		wr(5'h0c, 16'h0123);
		wr(5'h0d, 16'h0456);
		for (int i = 0; i < 11; i++) begin
			wr(5'h01, lcfg[i]);
			repeat (6) @(posedge clk);
			chk(load_rate, lexp[i]);
			chk(load_model_flag, lcfg[i][0]);
			rd(5'h00, {15'h0000, lcfg[i][0]});
		end
		$display("test load select done");
		wr(5'h02, 16'h0011);
		wr(5'h03, 16'h0022);
		wr(5'h01, 16'h0012);
		repeat (2) @(posedge clk);
		chk(reserve_mah, 16'h0011);
		chk(reserve_cwh, 16'h0022);
		chk(reserve_comp_select, 1'b1);
		$display("test reserve done");
		meas.dvdt_uv <= 16'h0002;
		meas.mean_current <= 16'h0000;
		ticks(40);
		chk(relax_active, 1'b0);
		meas.mean_current <= 16'hffce;
		ticks(1);
		meas.mean_current <= 16'h0000;
		ticks(40);
		chk(relax_active, 1'b0);
		ticks(25);
		chk(relax_active, 1'b1);
		ticks(4);
		chk({ocv_read_en, qmax_update_en}, 2'b11);
		meas.dvdt_uv <= 16'h0008;
		ticks(2);
		chk(qmax_update_en, 1'b0);
		meas.dvdt_uv <= 16'h0002;
		ticks(2);
		$display("test relax entry done");
		wr(5'h0e, 16'h0300);
		chk(qmax, 16'h0300);
		wr(5'h10, 16'h0020);
		rd(5'h0f, 16'h0002);
		wr(5'h10, 16'h0021);
		rd(5'h0f, 16'h0006);
		wr(5'h10, 16'h0021);
		rd(5'h0f, 16'h0004);
		learn_cycle <= 1'b1;
		qmax_candidate <= 16'h0400;
		qmax_candidate_valid <= 1'b1;
		@(posedge clk);
		qmax_candidate_valid <= 1'b0;
		repeat (3) @(posedge clk);
		chk(qmax, 16'h0400);
		rd(5'h0f, 16'h0005);
		ra_learned <= 1'b1;
		@(posedge clk);
		ra_learned <= 1'b0;
		repeat (3) @(posedge clk);
		rd(5'h0f, 16'h0006);
		learn_cycle <= 1'b0;
		$display("test learning done");
		meas.mean_current <= 16'h0032;
		ticks(30);
		meas.mean_current <= 16'h0000;
		ticks(1);
		meas.mean_current <= 16'h0032;
		ticks(40);
		chk(relax_active, 1'b1);
		ticks(25);
		chk(relax_active, 1'b0);
		$display("test relax exit done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
